// >>> inc/spfc_map.svh
// offsets, field positions, reset values and cycle counts of the self-program flash control
// What this block does
// [RQ1] enable opens four-cycle store window, self-clears
// [RQ2] plain store fills buffer word, pointer lsb ignored
// [RQ3] enable held through erase/write, clears when done
// [RQ4] erase command erases page from pointer
// [RQ5] write command moves buffer into page
// [RQ6] erase/write selects clear on done or timeout
// [RQ7] processor stalled during halting-section erase/write
// [RQ8] readable-section operation sets busy, blocks reads
// [RQ9] busy cleared by re-enable or buffer load
// [RQ10] re-enable only after enable clears, never busy
// [RQ11] re-enable during buffer load aborts and discards
// [RQ12] lock command programs lock bits from low data
// [RQ13] load within three cycles returns lock/fuse byte
// [RQ14] signature select: load reads row, store ignored
// [RQ15] ready interrupt requested while enable is clear
// [RQ16] only listed command patterns arm the sequencer
// [RQ17] register resets zero, data 0x57, io 0x37
// [RQ18] six lock bits default one, chip erase restores
// [RQ19] pattern 11 free, 10 locks programming and fuses
// [RQ20] pattern 00 also locks verify and boot bits
// [RQ21] software keeps pointer bit 0 zero for stores
// [RQ22] boot field 10 blocks stores to application
// [RQ23] windows count from the register write cycle
// [RQ24] erase/write finish only on flash done input
`ifndef SPFC_MAP_SVH
`define SPFC_MAP_SVH
`define SPFC_CSR_DATA_OFF  8'h57
`define SPFC_IO_DELTA      8'h20
`define SPFC_CSR_RESET     8'h00
`define SPFC_BIT_ENABLE    0
`define SPFC_BIT_IRQ_EN    7
`define SPFC_BIT_REENABLE  4
`define SPFC_PAT_STORE     6'h01
`define SPFC_PAT_ERASE     6'h03
`define SPFC_PAT_WRITE     6'h05
`define SPFC_PAT_LOCK      6'h09
`define SPFC_PAT_REENABLE  6'h11
`define SPFC_PAT_SIGNATURE 6'h21
`define SPFC_LOCK_RESET    8'hff
`define SPFC_STORE_WINDOW  3'd4
`define SPFC_LOAD_WINDOW   3'd3
`define SPFC_PAGE_WORDS    64
`define SPFC_HALTING_WRITE_SECTION_START    13'h1c00
`define SPFC_BOOT_START    13'h1c00
`define SPFC_ERASED_WORD   16'hffff
`endif

// >>> inc/spfc_pkg.sv
// types shared by the self-program flash control
package spfc_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_BUSY  = 2'b10
   } spfc_state_type;

   typedef struct packed {
      logic       wr;        // register write strobe
      logic       rd;        // register read strobe
      logic       io_space;  // address given in i/o space
      logic [7:0] addr;
      logic [7:0] wdata;
   } spfc_bus_type;

   typedef struct packed {
      logic        store;    // store_program_instr executes
      logic        load;     // load_program_instr executes
      logic [15:0] pointer;  // address_pointer
      logic [7:0]  low_data;
      logic [7:0]  high_data;
   } spfc_instr_type;

   typedef struct packed {
      logic       start;     // one-cycle start pulse
      logic       erase;
      logic       write;
      logic [6:0] page;
   } spfc_flash_cmd_type;

   typedef struct packed {
      logic ext_prog_lock;
      logic ext_verify_lock;
      logic fuse_lock;
      logic bootlock_lock;
      logic app_store_block;
      logic boot_store_block;
   } spfc_prot_type;
endpackage : spfc_pkg

// >>> design/spfc_arm_window.sv
// arming window counter for store and load instructions
`timescale 1ns/1ps
`include "spfc_map.svh"
module spfc_arm_window (
   input  wire logic clk,        // cpu clock
   input  wire logic rst_b,      // synchronised reset, active low
   input  wire logic load,       // register write arms the window
   input  wire logic clear,      // window consumed
   output logic      store_open, // store may be taken
   output logic      load_open,  // load may be taken
   output logic      expire      // last cycle of window
);
   logic [2:0] count;
   logic [2:0] next_count;

   always_comb begin
      next_count = count;
      if (load) begin
         next_count = `SPFC_STORE_WINDOW; // RQ23
      end else if (clear || count == 3'd0) begin
         next_count = 3'd0;
      end else begin
         next_count = count - 3'd1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= 3'd0;
      end else begin
         count <= next_count;
      end
   end

   assign store_open = (count != 3'd0);
   // load window is the first three of the four store cycles
   assign load_open  = (count > (`SPFC_STORE_WINDOW - `SPFC_LOAD_WINDOW)); // RQ13
   assign expire     = (count == 3'd1);
endmodule : spfc_arm_window

// >>> design/spfc_page_buffer.sv
// temporary page buffer, one word per entry
`timescale 1ns/1ps
`include "spfc_map.svh"
module spfc_page_buffer (
   input  wire logic        clk,     // cpu clock
   input  wire logic        rst_b,   // synchronised reset, active low
   input  wire logic        wr,      // store one word
   input  wire logic [5:0]  wr_idx,  // word within page
   input  wire logic [15:0] wr_data, // high:low data pair
   input  wire logic        clear,   // discard all words
   input  wire logic [5:0]  rd_idx,  // flash array read index
   output logic      [15:0] rd_data  // registered read word
);
   logic [15:0] mem [`SPFC_PAGE_WORDS];
   logic [`SPFC_PAGE_WORDS-1:0] valid;
   logic [`SPFC_PAGE_WORDS-1:0] next_valid;
   logic [15:0] next_rd_data;

   // valid bits make a clear one cycle instead of wiping the array
   always_comb begin
      next_valid = valid;
      // a store in the same cycle as a discard survives it
      if (clear) begin
         next_valid = '0;
      end
      if (wr) begin
         next_valid[wr_idx] = 1'b1;
      end
      next_rd_data = valid[rd_idx] ? mem[rd_idx] : `SPFC_ERASED_WORD;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         valid   <= '0;
         rd_data <= `SPFC_ERASED_WORD;
      end else begin
         valid   <= next_valid;
         rd_data <= next_rd_data;
      end
   end

   always_ff @(posedge clk) begin
      if (wr) begin
         mem[wr_idx] <= wr_data;
      end
   end
endmodule : spfc_page_buffer

// >>> design/spfc_top.sv
// self-program flash control: control register, command sequencer, lock byte
`timescale 1ns/1ps
`include "spfc_map.svh"
module spfc_top (
   input  wire logic                        clk,            // cpu clock, 125 MHz
   input  wire logic                        rst_b,          // async reset, active low
   input  wire spfc_pkg::spfc_bus_type      bus,            // register access
   output logic      [7:0]                  rdata,          // register read data
   input  wire spfc_pkg::spfc_instr_type    instr,          // store/load instruction
   input  wire logic                        global_irq_en,  // status global enable
   input  wire logic                        flash_done,     // flash operation finished
   input  wire logic [5:0]                  flash_rd_idx,   // buffer word wanted
   input  wire logic [7:0]                  fuse_data,      // fuse byte
   input  wire logic [7:0]                  sig_data,       // signature row byte
   input  wire logic                        chip_erase,     // chip erase pulse
   output logic                             load_valid,     // load result valid
   output logic      [7:0]                  load_data,      // lock/fuse/signature
   output spfc_pkg::spfc_flash_cmd_type     flash_cmd,      // erase/write start
   output logic      [15:0]                 flash_wdata,    // buffer word
   output logic                             cpu_stall,      // halt processor
   output logic                             rww_read_block, // readable section blocked
   output logic                             irq_req,        // ready interrupt
   output logic      [7:0]                  lock_state,     // lock bit byte
   output spfc_pkg::spfc_prot_type          prot            // decoded protection
);
   logic rst_meta_b;
   logic rst_sync_b;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   spfc_pkg::spfc_state_type state, next_state;
   logic       enable, next_enable;
   logic       irq_en, next_irq_en;
   logic       busy, next_busy;
   logic [5:1] cmd, next_cmd;
   logic       loading, next_loading;
   logic [7:0] next_rdata, next_load_data, next_lock;
   logic       next_load_valid, next_stall, next_irq;
   spfc_pkg::spfc_flash_cmd_type next_flash_cmd;
   spfc_pkg::spfc_prot_type      next_prot;

   logic        win_load, win_clear, store_open, load_open, expire;
   logic        buf_wr, buf_clear;
   logic        csr_hit, pattern_ok;
   logic [12:0] word_addr;
   logic        in_rww, store_blocked;
   logic [5:0]  pattern;
   logic [7:0]  csr;

   assign csr       = {irq_en, busy, cmd, enable};
   assign pattern   = bus.wdata[5:0];
   // i/o instructions see the register 0x20 below its data address
   assign csr_hit   = bus.addr == (bus.io_space ? (`SPFC_CSR_DATA_OFF - `SPFC_IO_DELTA)
                                                : `SPFC_CSR_DATA_OFF); // RQ17
   assign pattern_ok = pattern == `SPFC_PAT_STORE || pattern == `SPFC_PAT_ERASE
                    || pattern == `SPFC_PAT_WRITE || pattern == `SPFC_PAT_LOCK
                    || pattern == `SPFC_PAT_REENABLE
                    || pattern == `SPFC_PAT_SIGNATURE; // RQ16
   assign word_addr = instr.pointer[13:1]; // RQ2
   assign in_rww    = word_addr < `SPFC_HALTING_WRITE_SECTION_START;
   assign store_blocked = (word_addr < `SPFC_BOOT_START) ? prot.app_store_block
                                                         : prot.boot_store_block; // RQ22

   spfc_arm_window u_window (
      .clk        (clk),
      .rst_b      (rst_sync_b),
      .load       (win_load),
      .clear      (win_clear),
      .store_open (store_open),
      .load_open  (load_open),
      .expire     (expire)
   );

   spfc_page_buffer u_buffer (
      .clk     (clk),
      .rst_b   (rst_sync_b),
      .wr      (buf_wr),
      .wr_idx  (instr.pointer[6:1]),
      .wr_data ({instr.high_data, instr.low_data}),
      .clear   (buf_clear),
      .rd_idx  (flash_rd_idx),
      .rd_data (flash_wdata)
   );

   always_comb begin
      next_state      = state;
      next_enable     = enable;
      next_irq_en     = irq_en;
      next_busy       = busy;
      next_cmd        = cmd;
      next_loading    = loading;
      next_lock       = lock_state;
      next_stall      = cpu_stall;
      next_load_valid = 1'b0;
      next_load_data  = load_data;
      next_flash_cmd  = '0;
      win_load        = 1'b0;
      win_clear       = 1'b0;
      buf_wr          = 1'b0;
      buf_clear       = 1'b0;
      next_rdata      = (bus.rd && csr_hit) ? csr : 8'h00;

      if (bus.wr && csr_hit) begin
         next_irq_en = bus.wdata[`SPFC_BIT_IRQ_EN];
         // abort the page load even when the command itself is refused
         if (bus.wdata[`SPFC_BIT_REENABLE] && loading) begin
            next_loading = 1'b0; // RQ11
            buf_clear    = 1'b1; // RQ11
         end
         // a busy or armed sequencer ignores new commands
         if (state == spfc_pkg::ST_IDLE && pattern_ok) begin // RQ10 RQ16
            next_enable = 1'b1;
            next_cmd    = pattern[5:1];
            next_state  = spfc_pkg::ST_ARMED;
            win_load    = 1'b1; // RQ23
         end
      end

      unique case (state)
         spfc_pkg::ST_IDLE: begin
         end
         spfc_pkg::ST_ARMED: begin
            if (instr.store && store_open) begin
               win_clear   = 1'b1;
               next_enable = 1'b0; // RQ1
               next_cmd    = '0;
               next_state  = spfc_pkg::ST_IDLE;
               unique case ({cmd, 1'b1})
                  `SPFC_PAT_STORE: begin
                     buf_wr       = 1'b1; // RQ2
                     next_loading = 1'b1;
                     next_busy    = 1'b0; // RQ9
                  end
                  `SPFC_PAT_ERASE, `SPFC_PAT_WRITE: begin
                     if (!store_blocked) begin
                        next_flash_cmd.start = 1'b1; // RQ4 RQ5
                        next_flash_cmd.erase = cmd[1];
                        next_flash_cmd.write = cmd[2];
                        next_flash_cmd.page  = instr.pointer[13:7];
                        next_enable = 1'b1; // RQ3
                        next_cmd    = cmd;
                        next_state  = spfc_pkg::ST_BUSY;
                        next_busy   = busy | in_rww; // RQ8
                        next_stall  = !in_rww; // RQ7
                     end
                  end
                  `SPFC_PAT_LOCK: begin
                     // lock bits only program toward zero
                     next_lock = lock_state & {2'b11, instr.low_data[5:0]}; // RQ12
                  end
                  `SPFC_PAT_REENABLE: begin
                     next_busy = 1'b0; // RQ9 RQ10
                  end
                  default: begin
                     // signature select: store does nothing
                  end
               endcase
            end else if (instr.load && load_open && (cmd[3] || cmd[5])) begin
               next_load_valid = 1'b1; // RQ13 RQ14
               next_load_data  = cmd[5] ? sig_data
                                        : (instr.pointer[0] ? fuse_data : lock_state);
            end else if (expire) begin
               next_enable = 1'b0; // RQ1 RQ6
               next_cmd    = '0;
               next_state  = spfc_pkg::ST_IDLE;
            end
         end
         spfc_pkg::ST_BUSY: begin
            if (flash_done) begin // RQ24
               next_enable = 1'b0; // RQ3
               next_cmd    = '0; // RQ6
               next_stall  = 1'b0;
               next_state  = spfc_pkg::ST_IDLE;
               if (cmd[2]) begin
                  next_loading = 1'b0;
                  buf_clear    = 1'b1;
               end
            end
         end
         default: begin
            next_state  = spfc_pkg::ST_IDLE;
            next_enable = 1'b0;
            next_cmd    = '0;
            next_stall  = 1'b0;
         end
      endcase

      if (chip_erase) begin
         next_lock = `SPFC_LOCK_RESET; // RQ18
      end
      next_irq = next_irq_en && global_irq_en && !next_enable; // RQ15
      next_prot.ext_prog_lock    = !(next_lock[1] && next_lock[0]); // RQ19
      next_prot.fuse_lock        = !(next_lock[1] && next_lock[0]); // RQ19
      next_prot.ext_verify_lock  = !next_lock[1] && !next_lock[0]; // RQ20
      next_prot.bootlock_lock    = !next_lock[1] && !next_lock[0]; // RQ20
      next_prot.app_store_block  = !next_lock[2]; // RQ22
      next_prot.boot_store_block = !next_lock[4];
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state          <= spfc_pkg::ST_IDLE;
         {irq_en, busy, cmd, enable} <= `SPFC_CSR_RESET; // RQ17
         loading        <= 1'b0;
         lock_state     <= `SPFC_LOCK_RESET; // RQ18
         cpu_stall      <= 1'b0;
         rww_read_block <= 1'b0;
         irq_req        <= 1'b0;
         rdata          <= 8'h00;
         load_valid     <= 1'b0;
         load_data      <= 8'h00;
         flash_cmd      <= '0;
         prot           <= '0;
      end else begin
         state          <= next_state;
         enable         <= next_enable;
         irq_en         <= next_irq_en;
         busy           <= next_busy;
         cmd            <= next_cmd;
         loading        <= next_loading;
         lock_state     <= next_lock;
         cpu_stall      <= next_stall;
         rww_read_block <= next_busy; // RQ8
         irq_req        <= next_irq;
         rdata          <= next_rdata;
         load_valid     <= next_load_valid;
         load_data      <= next_load_data;
         flash_cmd      <= next_flash_cmd;
         prot           <= next_prot;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_b);

   a_window_timeout: assert property ( // RQ1 RQ6
      $rose(state == spfc_pkg::ST_ARMED) ##0 (!instr.store [*4]) |=> !enable && cmd == '0)
      else $error("arming window did not close after four cycles");
   a_store_completes: assert property ( // RQ1 RQ2 RQ9
      state == spfc_pkg::ST_ARMED && store_open && instr.store && cmd == '0
      |=> !enable && !busy && state == spfc_pkg::ST_IDLE)
      else $error("plain store did not complete");
   a_busy_holds_enable: assert property ( // RQ3 RQ24
      state == spfc_pkg::ST_BUSY && !flash_done |=> enable && state == spfc_pkg::ST_BUSY)
      else $error("enable dropped before flash done");
   a_done_clears_bits: assert property ( // RQ3 RQ6
      state == spfc_pkg::ST_BUSY && flash_done |=> !enable && !cmd[1] && !cmd[2] && !cpu_stall)
      else $error("flash done did not clear command bits");
   a_stall_or_busy: assert property ( // RQ7 RQ8
      flash_cmd.start |-> cpu_stall || rww_read_block)
      else $error("flash operation neither stalls nor blocks reads");
   a_reject_pattern: assert property ( // RQ16
      bus.wr && csr_hit && !pattern_ok && state == spfc_pkg::ST_IDLE
      |=> state == spfc_pkg::ST_IDLE && !enable)
      else $error("illegal command pattern took effect");
   a_irq_level: assert property ( // RQ15
      enable |-> !irq_req)
      else $error("ready interrupt raised while enable set");
   a_lock_only_programs: assert property ( // RQ18
      !$past(chip_erase) |-> (lock_state & ~$past(lock_state)) == 8'h00)
      else $error("lock bit returned to one without chip erase");
   a_load_abort: assert property ( // RQ11
      bus.wr && csr_hit && bus.wdata[`SPFC_BIT_REENABLE] && loading |=> !loading)
      else $error("re-enable write did not abort page load");

   c_erase_done: cover property (flash_cmd.start && flash_cmd.erase ##[1:50] flash_done);
   c_buffer_store: cover property (buf_wr);
   c_lock_read: cover property (load_valid && cmd[3]);
   c_page_write: cover property (flash_cmd.start && flash_cmd.write ##[1:50] flash_done);
   c_reenable: cover property (rww_read_block ##1 !rww_read_block);
endmodule : spfc_top

// >>> testbench/spfc_cpu_model.sv
// processor core model issuing store and load program instructions
`timescale 1ns/1ps
module spfc_cpu_model (
   input  wire logic                clk,   // cpu clock
   output spfc_pkg::spfc_instr_type instr  // instruction stream to the block
);
   initial begin
      instr = '0;
   end

   // one instruction per call, launched on a falling edge; caller chooses the delay
   task automatic issue(input logic st, input logic [15:0] ptr, input logic [15:0] dat);
      @(negedge clk);
      instr.store   = st;
      instr.load    = !st;
      instr.pointer = st ? {ptr[15:1], 1'b0} : ptr;
      {instr.high_data, instr.low_data} = dat;
      @(negedge clk);
      instr.store   = 1'b0;
      instr.load    = 1'b0;
      // released operands must not look like a repeat of the last value
      instr.pointer = ~instr.pointer;
      {instr.high_data, instr.low_data} = ~dat;
   endtask : issue
endmodule : spfc_cpu_model

// >>> testbench/test_self_program_flash_control.sv
// self-checking bench for the self-program flash control
`timescale 1ns/1ps
module test_self_program_flash_control;
   logic                         clk;
   logic                         rst_b;
   logic                         global_irq_en;
   logic                         flash_done;
   logic                         chip_erase;
   logic [5:0]                   flash_rd_idx;
   spfc_pkg::spfc_bus_type       bus;
   spfc_pkg::spfc_instr_type     instr;
   spfc_pkg::spfc_flash_cmd_type flash_cmd;
   spfc_pkg::spfc_prot_type      prot;
   logic [7:0]                   rdata;
   logic [7:0]                   load_data;
   logic [7:0]                   lock_state;
   logic [15:0]                  flash_wdata;
   logic                         load_valid;
   logic                         cpu_stall;
   logic                         rww_read_block;
   logic                         irq_req;
   int                           miscompares;
   int                           cmp_count;
   logic [7:0]                   bad [3] = '{8'h07, 8'h13, 8'h02};

   spfc_top dut (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .instr(instr),
      .global_irq_en(global_irq_en), .flash_done(flash_done), .flash_rd_idx(flash_rd_idx),
      .fuse_data(8'h5a), .sig_data(8'ha6), .chip_erase(chip_erase), .load_valid(load_valid),
      .load_data(load_data), .flash_cmd(flash_cmd), .flash_wdata(flash_wdata),
      .cpu_stall(cpu_stall), .rww_read_block(rww_read_block), .irq_req(irq_req),
      .lock_state(lock_state), .prot(prot));

   spfc_cpu_model cpu (.clk(clk), .instr(instr));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [7:0] d, input logic [7:0] a = 8'h57, input logic io = 1'b0);
      @(negedge clk);
      bus = '{1'b1, 1'b0, io, a, d};
      @(negedge clk);
      bus.wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] exp);
      @(negedge clk);
      bus = '{1'b0, 1'b1, 1'b0, 8'h57, 8'h00};
      @(negedge clk);
      bus.rd = 1'b0;
      check("csr", {8'h00, rdata}, {8'h00, exp});
   endtask : rd

   task automatic buf_chk(input logic [5:0] idx, input logic [15:0] exp);
      @(negedge clk);
      flash_rd_idx = idx;
      @(negedge clk);
      check("buffer", flash_wdata, exp);
   endtask : buf_chk

   task automatic done();
      @(negedge clk);
      flash_done = 1'b1;
      @(negedge clk);
      flash_done = 1'b0;
   endtask : done

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      bus = '0;
      rst_b = 1'b0;
      global_irq_en = 1'b1;
      flash_done = 1'b0;
      chip_erase = 1'b0;
      flash_rd_idx = '0;
      miscompares = 0;
      cmp_count = 0;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      rd(8'h00);
      check("lock", {8'h00, lock_state}, 16'h00ff);
      check("irq", {15'h0, irq_req}, 16'h0);
      $display("test reset done");
      wr(8'h80, 8'h37, 1'b1);
      wr(8'h00, 8'h58);
      rd(8'h80);
      check("irq", {15'h0, irq_req}, 16'h1);
      global_irq_en = 1'b0;
      repeat (2) @(negedge clk);
      check("irq", {15'h0, irq_req}, 16'h0);
      global_irq_en = 1'b1;
      wr(8'h81);
      @(negedge clk);
      check("irq", {15'h0, irq_req}, 16'h0);
      repeat (5) @(negedge clk);
      rd(8'h80);
      check("irq", {15'h0, irq_req}, 16'h1);
      wr(8'h00);
      $display("test address and interrupt done");
      // store in the last window cycle is taken, one cycle later is not
      wr(8'h01);
      repeat (2) @(negedge clk);
      cpu.issue(1'b1, 16'h000e, 16'h1234);
      buf_chk(6'd7, 16'h1234);
      rd(8'h00);
      wr(8'h01);
      repeat (3) @(negedge clk);
      cpu.issue(1'b1, 16'h0010, 16'hbeef);
      buf_chk(6'd8, 16'hffff);
      $display("test store window done");
      wr(8'h03);
      cpu.issue(1'b1, 16'h0180, 16'h0000);
      check("cmd", {6'h00, flash_cmd}, {6'h00, 3'b110, 7'h03});
      check("block", {15'h0, rww_read_block}, 16'h1);
      check("stall", {15'h0, cpu_stall}, 16'h0);
      rd(8'h43);
      wr(8'h11);
      cpu.issue(1'b1, 16'h0000, 16'h0000);
      check("block", {15'h0, rww_read_block}, 16'h1);
      done();
      rd(8'h40);
      wr(8'h11);
      cpu.issue(1'b1, 16'h0000, 16'h0000);
      check("block", {15'h0, rww_read_block}, 16'h0);
      rd(8'h00);
      $display("test erase and re-enable done");
      wr(8'h01);
      cpu.issue(1'b1, 16'h0004, 16'ha55a);
      wr(8'h11);
      buf_chk(6'd2, 16'hffff);
      repeat (5) @(negedge clk);
      wr(8'h05);
      cpu.issue(1'b1, 16'h3800, 16'h0000);
      check("cmd", {6'h00, flash_cmd}, {6'h00, 3'b101, 7'h70});
      check("stall", {15'h0, cpu_stall}, 16'h1);
      done();
      check("stall", {15'h0, cpu_stall}, 16'h0);
      rd(8'h00);
      foreach (bad[i]) begin
         wr(bad[i]);
         rd(8'h00);
      end
      $display("test write and refusals done");
      wr(8'h09);
      cpu.issue(1'b0, 16'h0000, 16'h0000);
      check("load", {7'h00, load_valid, load_data}, 16'h01ff);
      // a load leaves the window armed: let it expire before re-arming
      repeat (2) @(negedge clk);
      wr(8'h09);
      cpu.issue(1'b0, 16'h0001, 16'h0000);
      check("load", {7'h00, load_valid, load_data}, 16'h015a);
      repeat (2) @(negedge clk);
      wr(8'h09);
      cpu.issue(1'b1, 16'h0000, 16'h55fc);
      @(negedge clk);
      check("lock", {8'h00, lock_state}, 16'h00fc);
      check("prot", {10'h000, prot}, 16'h003c);
      chip_erase = 1'b1;
      @(negedge clk);
      chip_erase = 1'b0;
      @(negedge clk);
      check("lock", {8'h00, lock_state}, 16'h00ff);
      wr(8'h09);
      cpu.issue(1'b1, 16'h0000, 16'h00fa);
      @(negedge clk);
      check("prot", {10'h000, prot}, 16'h002a);
      wr(8'h03);
      cpu.issue(1'b1, 16'h0180, 16'h0000);
      check("cmd", {6'h00, flash_cmd}, 16'h0000);
      rd(8'h00);
      $display("test lock byte done");
      wr(8'h21);
      cpu.issue(1'b0, 16'h0000, 16'h0000);
      check("load", {7'h00, load_valid, load_data}, 16'h01a6);
      repeat (2) @(negedge clk);
      wr(8'h21);
      cpu.issue(1'b1, 16'h0004, 16'h9999);
      buf_chk(6'd2, 16'hffff);
      $display("test signature done");
      print_verdict();
   end

   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
endmodule : test_self_program_flash_control
